// ### dv/epd_dma_handshake_assertions.sv
// epd_dma_handshake_assertions.sv: port-level checks of the dma block
// assumes: bound into epd_dma_handshake; config held while a transfer runs
`timescale 1ns/1ps
module epd_dma_handshake_assertions #(
    parameter DW = 32
) (
    input wire clk,
    input wire sys_rst,
    input wire [1:0] handshakeMode,
    input wire [1:0] waitMode,
    input wire [2:0] waitStates,
    input wire holdCycleEnable,
    input wire idleCycleEnable,
    input wire mp_space_wait_enable,
    input wire targetIsSdram,
    input wire [DW-1:0] xferWriteData,
    input wire xferDone,
    input wire dma_request_n,
    input wire dma_grant_n,
    input wire addrOe,
    input wire rdOut_n,
    input wire wrOut_n,
    input wire [DW-1:0] dataOut,
    input wire dataOe,
    input wire ackOut,
    input wire ackOe,
    input wire memWrite,
    input wire memRead
);
    reg [7:0] lowCnt; // length of the current grant-low run
    // run length kept in logic: a repetition count cannot follow waitStates
    always @(posedge clk)
    begin
        if (sys_rst || dma_grant_n)
            lowCnt <= 8'h00;
        else
            lowCnt <= lowCnt + 8'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_grant_after_req: assert property ($fell(dma_grant_n) |->
        !$past(dma_request_n, 2) || !$past(dma_request_n, 3) ||
        !$past(dma_request_n, 4)) else $error("grant without request");
    a_plain_no_strobe: assert property (handshakeMode == 2'h0 |->
        rdOut_n && wrOut_n) else $error("strobe in plain mode");
    a_ext_drives_bus: assert property (handshakeMode == 2'h1 &&
        !dma_grant_n |-> addrOe && !(rdOut_n && wrOut_n))
        else $error("external transfer without bus");
    a_sdram_no_move: assert property (handshakeMode == 2'h1 &&
        targetIsSdram |-> dma_grant_n && rdOut_n && wrOut_n)
        else $error("external mode moved pins to sdram");
    a_paced_no_grant: assert property (handshakeMode == 2'h2 |->
        dma_grant_n) else $error("grant in paced mode");
    a_write_data_out: assert property (!wrOut_n |->
        dataOe && dataOut == xferWriteData) else $error("bad write data");
    a_grant_wait_len: assert property ($rose(dma_grant_n) &&
        waitMode == 2'h1 |-> lowCnt >= 8'h02 && lowCnt > waitStates)
        else $error("grant low too short");
    a_gap_before_strobe: assert property ($rose(dma_grant_n) &&
        (holdCycleEnable || idleCycleEnable) |-> (rdOut_n && wrOut_n)[*3])
        else $error("no gap clock");
    a_grant_ends_done: assert property ($rose(dma_grant_n) |->
        xferDone) else $error("grant rose without done");
    a_slave_mem_access: assert property ($rose(ackOe) |->
        ##[0:2] (memRead || memWrite)) else $error("slave no mem access");
    a_slave_ack_soon: assert property ($rose(ackOe) |->
        ##[1:3] ackOut) else $error("slave ack late");
    a_slave_mp_wait: assert property ($rose(ackOe) &&
        mp_space_wait_enable |-> ##1 !ackOut) else $error("no slave wait");
endmodule // epd_dma_handshake_assertions

bind epd_dma_handshake epd_dma_handshake_assertions #(.DW(DW)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .handshakeMode(handshakeMode),
    .waitMode(waitMode), .waitStates(waitStates),
    .holdCycleEnable(holdCycleEnable), .idleCycleEnable(idleCycleEnable),
    .mp_space_wait_enable(mp_space_wait_enable),
    .targetIsSdram(targetIsSdram), .xferWriteData(xferWriteData),
    .xferDone(xferDone), .dma_request_n(dma_request_n),
    .dma_grant_n(dma_grant_n), .addrOe(addrOe), .rdOut_n(rdOut_n),
    .wrOut_n(wrOut_n), .dataOut(dataOut), .dataOe(dataOe),
    .ackOut(ackOut), .ackOe(ackOe), .memWrite(memWrite), .memRead(memRead)
);

// ### dv/epd_dma_handshake_test.sv
// epd_dma_handshake_test.sv: directed tests of the dma handshake block
// assumes: 50 MHz clock, inputs driven at the falling edge
`timescale 1ns/1ps
module epd_dma_handshake_test;
    localparam [31:0] WORD = 32'hC3A50F96;
    localparam [23:0] SADDR = 24'h00A5C3;
    reg clk, sys_rst, holdCycleEnable, idleCycleEnable, targetIsSdram;
    reg mp_space_wait_enable, xferWrite, slaveSelect, slaveRd_n, slaveWr_n;
    reg go;
    reg [1:0] handshakeMode, waitMode;
    reg [2:0] waitStates, i;
    reg [3:0] extra, ackDelay;
    reg [31:0] memReadData;
    wire xferDone, xferRefused, dma_request_n, dma_grant_n, addrOe;
    wire rdOut_n, wrOut_n, ackIn, dataOe, ackOut, ackOe, slaveDataOe;
    wire memWrite, memRead, sync_write_select_n;
    wire [3:0] memory_select_n;
    wire [23:0] addrOut, memAddr;
    wire [31:0] xferReadData, dataIn, dataOut, slaveDataOut, memWriteData;
    integer n_errors, checked, lastT, t0;
    epd_dma_handshake u_dut (.clk(clk), .sys_rst(sys_rst),
        .handshakeMode(handshakeMode), .waitMode(waitMode),
        .waitStates(waitStates), .holdCycleEnable(holdCycleEnable),
        .idleCycleEnable(idleCycleEnable), .targetIsSdram(targetIsSdram),
        .mp_space_wait_enable(mp_space_wait_enable), .xferWrite(xferWrite),
        .xferAddr(SADDR), .xferWriteData(WORD), .xferSelect(4'h1),
        .xferDone(xferDone), .xferRefused(xferRefused),
        .xferReadData(xferReadData), .dma_request_n(dma_request_n),
        .dma_grant_n(dma_grant_n), .addrOut(addrOut), .addrOe(addrOe),
        .rdOut_n(rdOut_n), .wrOut_n(wrOut_n),
        .sync_write_select_n(sync_write_select_n),
        .memory_select_n(memory_select_n), .ackIn(ackIn), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .slaveSelect(slaveSelect),
        .slaveRd_n(slaveRd_n), .slaveWr_n(slaveWr_n), .slaveAddrIn(SADDR),
        .ackOut(ackOut), .ackOe(ackOe), .slaveDataOut(slaveDataOut),
        .slaveDataOe(slaveDataOe), .memWrite(memWrite), .memRead(memRead),
        .memAddr(memAddr), .memWriteData(memWriteData),
        .memReadData(memReadData));
    epd_peripheral_model u_peer (.clk(clk), .go(go), .extra(extra),
        .ackDelay(ackDelay), .word(WORD), .dma_grant_n(dma_grant_n),
        .rdOut_n(rdOut_n), .wrOut_n(wrOut_n), .dma_request_n(dma_request_n),
        .ackIn(ackIn), .dataIn(dataIn));
    // ---------------------------------------
    // clock, memory answer and tasks
    // ---------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // memory answers at the next falling edge, half a cycle after the read, address-dependent
    always @(negedge clk) memReadData <= {8'h00, memAddr} ^ 32'h5A5A5A5A;
    task check(input [31:0] seen, input [31:0] want);
    begin
        checked = checked + 1;
        if (seen !== want)
        begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    end
    endtask
    task summarize;
    begin
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // one peripheral-driven transfer, waits for done or refusal
    task xfer(input [1:0] hm, input [1:0] wm, input wr, input [3:0] ex,
        input [3:0] ad, input sd);
    begin
        @(negedge clk);
        handshakeMode = hm;
        waitMode = wm;
        xferWrite = wr;
        targetIsSdram = sd;
        extra = ex;
        ackDelay = ad;
        go = 1'b1;
        @(negedge clk) go = 1'b0;
        lastT = 0;
        while (!xferDone && !xferRefused && lastT < 200)
        begin
            @(negedge clk);
            lastT = lastT + 1;
        end
        check(xferRefused, sd && hm == 2'h1);
        if (!wr && !(sd && hm == 2'h1))
            check(xferReadData, WORD);
        if (!(sd && hm == 2'h1))
        begin
            // bus pins still stand in the clock after done
            check({addrOe, memory_select_n}, hm ? 5'h1E : 5'h0F);
            if (hm != 2'h0)
                check(addrOut, SADDR);
        end
        check(lastT < 200 && lastT > ex, 1'b1);
        while (!dma_request_n) @(negedge clk);
        repeat (4) @(negedge clk);
    end
    endtask
    // one access by a remote master, then the strobe is dropped
    task slave(input wr, input mp);
    begin
        @(negedge clk);
        mp_space_wait_enable = mp;
        slaveSelect = 1'b1;
        slaveWr_n = !wr;
        slaveRd_n = wr;
        lastT = 0;
        while (!ackOut && lastT < 50)
        begin
            @(negedge clk);
            lastT = lastT + 1;
        end
        if (!wr)
            check(slaveDataOut, {8'h00, SADDR} ^ 32'h5A5A5A5A);
        check(memAddr, SADDR);
        slaveSelect = 1'b0;
        slaveWr_n = 1'b1;
        slaveRd_n = 1'b1;
        repeat (6) @(negedge clk);
        check({ackOe, slaveDataOe}, 2'b00);
    end
    endtask
    // ---------------------------------------
    // main sequence and watchdog
    // ---------------------------------------
    initial
    begin
        n_errors = 0;
        checked = 0;
        sys_rst = 1'b1;
        {holdCycleEnable, idleCycleEnable, targetIsSdram, go} = 4'h0;
        {mp_space_wait_enable, xferWrite, slaveSelect} = 3'h0;
        {slaveRd_n, slaveWr_n} = 2'h3;
        {handshakeMode, waitMode, extra, ackDelay} = 12'h000;
        waitStates = 3'h2;
        memReadData = 32'h00000000;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        for (i = 0; i < 6; i = i + 1)
            xfer(i[2:1], 2'h0, i[0], 4'h0, 4'h1, 1'b0);
        for (i = 0; i < 4; i = i + 1)
        begin
            xfer(2'h1, i[1:0], 1'b0, 4'h0, 4'hC, 1'b0);
            // internal and either finish on the count, ack comes late
            check(i[0] ? lastT < 12 : lastT > 12, 1'b1);
        end
        xfer(2'h0, 2'h0, 1'b0, 4'h9, 4'h0, 1'b0);
        xfer(2'h1, 2'h0, 1'b1, 4'h9, 4'h0, 1'b0);
        holdCycleEnable = 1'b1;
        xfer(2'h1, 2'h0, 1'b1, 4'h0, 4'h0, 1'b0);
        {holdCycleEnable, idleCycleEnable} = 2'h1;
        xfer(2'h0, 2'h0, 1'b0, 4'h0, 4'h0, 1'b0);
        xfer(2'h1, 2'h0, 1'b0, 4'h0, 4'h0, 1'b1);
        xfer(2'h2, 2'h0, 1'b0, 4'h0, 4'h0, 1'b1);
        slave(1'b1, 1'b0);
        slave(1'b0, 1'b0);
        t0 = lastT;
        slave(1'b0, 1'b1);
        check(lastT, t0 + 1);
        summarize;
    end
    initial
    begin
        #200000;
        n_errors = n_errors + 1;
        summarize;
    end
endmodule // epd_dma_handshake_test

// ### dv/epd_peripheral_model.sv
// epd_peripheral_model.sv: external peripheral asking for dma transfers
// assumes: go pulses one clock; grant, strobes low while the block works
`timescale 1ns/1ps
module epd_peripheral_model (
    input wire clk,
    input wire go,
    input wire [3:0] extra,
    input wire [3:0] ackDelay,
    input wire [31:0] word,
    input wire dma_grant_n,
    input wire rdOut_n,
    input wire wrOut_n,
    output reg dma_request_n,
    output reg ackIn,
    output reg [31:0] dataIn
);
    integer n; // active cycles seen so far
    integer k; // bounded wait for grant
    initial
    begin
        dma_request_n = 1'b1;
        ackIn = 1'b0;
        dataIn = 32'h00000000;
        n = 0;
    end
    // request held past grant by extra cycles to stretch the access
    always @(posedge go)
    begin
        @(negedge clk) dma_request_n = 1'b0;
        k = 0;
        while (dma_grant_n && rdOut_n && wrOut_n && k < 50)
        begin
            @(negedge clk);
            k = k + 1;
        end
        repeat (extra) @(negedge clk);
        dma_request_n = 1'b1;
    end
    // ack late by ackDelay; bus shows the inverse once released
    always @(negedge clk)
    begin
        if (dma_grant_n && rdOut_n && wrOut_n)
            n = 0;
        else
            n = n + 1;
        ackIn = (n > ackDelay);
        dataIn = (rdOut_n && dma_grant_n) ? ~word : word;
    end
endmodule // epd_peripheral_model

// ### verilog/epd_dma_handshake.v
// epd_dma_handshake.v: external-port dma handshake and bus-slave access
// assumes: one clock (clk, 50 MHz); pins arrive raw and all but slaveAddrIn are synchronised
// What this block does
// R1: request low starts a transfer, all modes
// R2: plain mode drives grant low for data
// R3: external mode uses address, strobes, selects, ack
// R4: external mode refuses sdram targets
// R5: paced mode uses strobes, never grant
// R6: write held off while request stays low
// R7: read prolonged one clock per request cycle
// R8: request sampled on clock edges
// R9: internal wait mode ignores acknowledge
// R10: first-cycle ack sampling per mode
// R11: later ack sampling per mode
// R12: strobe or grant lengthened by wait states
// R13: hold or idle adds one gap clock
// R14: slave accepts reads and writes
// R15: slave drives ack, data, then releases
// R16: mp wait enable adds slave wait state
// R17: grant low once per transfer, then high
`timescale 1ns/1ps
`include "epd_map.vh"
module epd_dma_handshake #(
    parameter AW = 24,
    parameter DW = 32
) (
    input wire clk,
    input wire sys_rst,
    // configuration
    input wire [1:0] handshakeMode,
    input wire [1:0] waitMode,
    input wire [`EPD_WAIT_W-1:0] waitStates,
    input wire holdCycleEnable,
    input wire idleCycleEnable,
    input wire mp_space_wait_enable,
    input wire targetIsSdram,
    // dma controller side
    input wire xferWrite,
    input wire [AW-1:0] xferAddr,
    input wire [DW-1:0] xferWriteData,
    input wire [3:0] xferSelect,
    output reg xferDone,
    output reg xferRefused,
    output reg [DW-1:0] xferReadData,
    // master pins
    input wire dma_request_n,
    output reg dma_grant_n,
    output reg [AW-1:0] addrOut,
    output reg addrOe,
    output reg rdOut_n,
    output reg wrOut_n,
    output reg sync_write_select_n,
    output reg [3:0] memory_select_n,
    input wire ackIn,
    input wire [DW-1:0] dataIn,
    output reg [DW-1:0] dataOut,
    output reg dataOe,
    // slave pins
    input wire slaveSelect,
    input wire slaveRd_n,
    input wire slaveWr_n,
    input wire [AW-1:0] slaveAddrIn,
    output reg ackOut,
    output reg ackOe,
    output reg [DW-1:0] slaveDataOut,
    output reg slaveDataOe,
    // internal memory and io_processor_regs port
    output reg memWrite,
    output reg memRead,
    output reg [AW-1:0] memAddr,
    output reg [DW-1:0] memWriteData,
    input wire [DW-1:0] memReadData
);
    // ----------------------------------------------
    // input synchronisers, two flops each
    // ----------------------------------------------
    reg reqMeta, reqSync; // request pin
    reg ackMeta, ackSync; // acknowledge pin
    reg selMeta, selSync; // slave select
    reg rdMeta, rdSync; // slave read strobe
    reg wrMeta, wrSync; // slave write strobe
    reg [DW-1:0] dinMeta, dinSync; // master read data

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            reqMeta <= 1'b1;
            reqSync <= 1'b1;
            ackMeta <= 1'b0;
            ackSync <= 1'b0;
            selMeta <= 1'b0;
            selSync <= 1'b0;
            rdMeta <= 1'b1;
            rdSync <= 1'b1;
            wrMeta <= 1'b1;
            wrSync <= 1'b1;
            dinMeta <= {DW{1'b0}};
            dinSync <= {DW{1'b0}};
        end
        else
        begin
            reqMeta <= dma_request_n; // [R8]
            reqSync <= reqMeta;
            ackMeta <= ackIn;
            ackSync <= ackMeta;
            selMeta <= slaveSelect;
            selSync <= selMeta;
            rdMeta <= slaveRd_n;
            rdSync <= rdMeta;
            wrMeta <= slaveWr_n;
            wrSync <= wrMeta;
            dinMeta <= dataIn;
            dinSync <= dinMeta;
        end
    end

    // ----------------------------------------------
    // master side: wait timer and ack sampling
    // ----------------------------------------------
    reg [2:0] state; // master state
    reg firstCycle; // first clock of an access
    reg isWrite; // latched direction
    wire waitDone; // programmed wait states elapsed
    wire startAccess; // load the wait timer
    wire reqLow; // synchronised request asserted
    reg ackOk; // access may complete on ack
    reg waitOk; // wait-state condition met

    assign reqLow = !reqSync;
    assign startAccess = (state == `EPD_ST_IDLE) && reqLow &&
        !(handshakeMode == `EPD_HS_EXT && targetIsSdram);

    epd_wait_timer #(.W(`EPD_WAIT_W)) masterWait (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(startAccess),
        .loadValue(waitStates), // [R12]
        .done(waitDone)
    );

    // completion decision by wait mode
    always @*
    begin
        ackOk = 1'b0;
        waitOk = 1'b0;
        case (waitMode)
            `EPD_WM_INTERNAL:
                waitOk = waitDone; // [R9]
            `EPD_WM_EXTERNAL:
                waitOk = ackSync; // [R10] [R11]
            `EPD_WM_EITHER:
                waitOk = ackSync || waitDone; // [R10] [R11]
            `EPD_WM_BOTH:
                // ack looked at only once the count is zero
                waitOk = waitDone && ackSync; // [R10] [R11]
            default:
                waitOk = waitDone;
        endcase
        // request held low stretches the access by one clock each
        ackOk = waitOk && !reqLow && !firstCycle; // [R6] [R7]
    end

    // ----------------------------------------------
    // master state machine
    // ----------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state <= `EPD_ST_IDLE;
            firstCycle <= 1'b0;
            isWrite <= 1'b0;
            xferDone <= 1'b0;
            xferRefused <= 1'b0;
            xferReadData <= {DW{1'b0}};
            dma_grant_n <= 1'b1;
            addrOut <= {AW{1'b0}};
            addrOe <= 1'b0;
            rdOut_n <= 1'b1;
            wrOut_n <= 1'b1;
            sync_write_select_n <= 1'b1;
            memory_select_n <= 4'hF;
            dataOut <= {DW{1'b0}};
            dataOe <= 1'b0;
        end
        else
        begin
            xferDone <= 1'b0;
            xferRefused <= 1'b0;
            firstCycle <= 1'b0;
            case (state)
                `EPD_ST_IDLE:
                begin
                    if (reqLow && handshakeMode == `EPD_HS_EXT &&
                        targetIsSdram)
                        xferRefused <= 1'b1; // [R4]
                    else if (reqLow) // [R1]
                    begin
                        state <= `EPD_ST_ACTIVE;
                        firstCycle <= 1'b1;
                        isWrite <= xferWrite;
                        // grant only in plain and external modes
                        dma_grant_n <= (handshakeMode ==
                            `EPD_HS_PACED); // [R2] [R5] [R17]
                        if (handshakeMode != `EPD_HS_PLAIN)
                        begin
                            // bus-cycle pins only when bus is used
                            addrOut <= xferAddr; // [R3] [R5]
                            addrOe <= 1'b1;
                            memory_select_n <= ~xferSelect;
                            rdOut_n <= xferWrite;
                            wrOut_n <= !xferWrite;
                            sync_write_select_n <= !xferWrite ||
                                (handshakeMode == `EPD_HS_PACED);
                        end
                        dataOut <= xferWriteData;
                        dataOe <= xferWrite;
                    end
                end
                `EPD_ST_ACTIVE:
                begin
                    if (ackOk) // [R12]
                    begin
                        dma_grant_n <= 1'b1; // [R17]
                        rdOut_n <= 1'b1;
                        wrOut_n <= 1'b1;
                        sync_write_select_n <= 1'b1;
                        if (!isWrite)
                            xferReadData <= dinSync;
                        xferDone <= 1'b1;
                        state <= `EPD_ST_HOLD;
                    end
                end
                `EPD_ST_HOLD:
                begin
                    // address and selects held through this clock
                    dataOe <= 1'b0;
                    if (holdCycleEnable || idleCycleEnable)
                        state <= `EPD_ST_GAP; // [R13]
                    else
                    begin
                        addrOe <= 1'b0;
                        memory_select_n <= 4'hF;
                        state <= `EPD_ST_IDLE;
                    end
                end
                `EPD_ST_GAP:
                begin
                    // one extra clock before the next strobe
                    addrOe <= 1'b0; // [R13]
                    memory_select_n <= 4'hF;
                    state <= `EPD_ST_IDLE;
                end
                default:
                    state <= `EPD_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------
    // slave side: accesses from another master
    // ----------------------------------------------
    reg [1:0] slState; // slave state
    reg slWrite; // latched slave direction
    wire slStrobe; // a strobe is low while selected

    assign slStrobe = selSync && (!rdSync || !wrSync);

    // the extra wait lets a late master strobe settle
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            slState <= `EPD_SL_IDLE;
            slWrite <= 1'b0;
            ackOut <= 1'b0;
            ackOe <= 1'b0;
            slaveDataOut <= {DW{1'b0}};
            slaveDataOe <= 1'b0;
            memWrite <= 1'b0;
            memRead <= 1'b0;
            memAddr <= {AW{1'b0}};
            memWriteData <= {DW{1'b0}};
        end
        else
        begin
            memWrite <= 1'b0;
            memRead <= 1'b0;
            case (slState)
                `EPD_SL_IDLE:
                begin
                    ackOut <= 1'b0;
                    if (slStrobe) // [R14]
                    begin
                        slWrite <= !wrSync;
                        memAddr <= slaveAddrIn;
                        memWriteData <= dinSync;
                        ackOe <= 1'b1;
                        if (mp_space_wait_enable)
                            slState <= `EPD_SL_WAIT; // [R16]
                        else
                        begin
                            memWrite <= !wrSync;
                            memRead <= wrSync;
                            slState <= `EPD_SL_ACK;
                        end
                    end
                end
                `EPD_SL_WAIT:
                begin
                    memWrite <= slWrite; // [R16]
                    memRead <= !slWrite;
                    slState <= `EPD_SL_ACK;
                end
                `EPD_SL_ACK:
                begin
                    ackOut <= 1'b1; // [R15]
                    slaveDataOut <= memReadData;
                    slaveDataOe <= !slWrite;
                    slState <= `EPD_SL_REL;
                end
                `EPD_SL_REL:
                begin
                    // release ack and data after the access
                    if (!slStrobe)
                    begin
                        ackOut <= 1'b0; // [R15]
                        ackOe <= 1'b0;
                        slaveDataOe <= 1'b0;
                        slState <= `EPD_SL_IDLE;
                    end
                end
                default:
                    slState <= `EPD_SL_IDLE;
            endcase
        end
    end
endmodule // epd_dma_handshake

// ### verilog/epd_map.vh
// epd_map.vh: constants for the external-port dma handshake block
// assumes: included by epd_dma_handshake.v and epd_wait_timer.v
`ifndef EPD_MAP_VH
`define EPD_MAP_VH
// handshake modes
`define EPD_HS_PLAIN 2'h0
`define EPD_HS_EXT 2'h1
`define EPD_HS_PACED 2'h2
// wait-state sampling modes of acknowledge
`define EPD_WM_EXTERNAL 2'h0
`define EPD_WM_INTERNAL 2'h1
`define EPD_WM_BOTH 2'h2
`define EPD_WM_EITHER 2'h3
// width of the wait-state count
`define EPD_WAIT_W 3
// master states
`define EPD_ST_IDLE 3'h0
`define EPD_ST_ACTIVE 3'h1
`define EPD_ST_HOLD 3'h2
`define EPD_ST_GAP 3'h3
// slave states
`define EPD_SL_IDLE 2'h0
`define EPD_SL_WAIT 2'h1
`define EPD_SL_ACK 2'h2
`define EPD_SL_REL 2'h3
`endif

// ### verilog/epd_wait_timer.v
// epd_wait_timer.v: loadable down-counter for wait states
// assumes: one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`include "epd_map.vh"
module epd_wait_timer #(
    parameter W = `EPD_WAIT_W
) (
    input wire clk,
    input wire sys_rst,
    input wire load,
    input wire [W-1:0] loadValue,
    output wire done
);
    reg [W-1:0] count; // remaining wait states

    // --------------------------------------------------
    // count down one per clock after a load
    // --------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
            count <= {W{1'b0}};
        else if (load)
            count <= loadValue;
        else if (count != {W{1'b0}})
            count <= count - {{(W-1){1'b0}}, 1'b1};
    end

    assign done = (count == {W{1'b0}}) && !load;
endmodule // epd_wait_timer
